/* File: verilog/ssr_pkg.sv */
// Purpose: shared constants and types of the serial memory slave
// Assumes: serial frame is opcode, address, then data, all msb first
// Notes: mode field position and codes are defaults for top parameters
package ssr_pkg;
  // field widths
  localparam int OPC_W = 8;
  localparam int ADDR_W = 16;
  localparam int WADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 5;
  localparam int CNT_W = 4;
  localparam int MODE_W = 2;
  localparam int MODE_LSB = 6;
  // opcodes
  localparam logic [OPC_W-1:0] OPC_READ = 8'h03;
  localparam logic [OPC_W-1:0] OPC_WRITE = 8'h02;
  localparam logic [OPC_W-1:0] OPC_SREAD = 8'h05;
  localparam logic [OPC_W-1:0] OPC_SWRITE = 8'h01;
  // last bit index of each field
  localparam logic [CNT_W-1:0] OPC_LAST = 4'h7;
  localparam logic [CNT_W-1:0] ADDR_LAST = 4'hF;
  localparam logic [CNT_W-1:0] BYTE_LAST = 4'h7;
  // access modes and status reset value
  typedef logic [MODE_W-1:0] ssr_mode_t;
  localparam ssr_mode_t MODE_WORD = 2'h0;
  localparam ssr_mode_t MODE_PAGE = 2'h2;
  localparam ssr_mode_t MODE_BURST = 2'h1;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h02;
endpackage

/* File: verilog/ssr_sync.sv */
// Purpose: two-flop level synchroniser, any width
// Assumes: each bit is a slow level or is sampled only while stable
// Notes: first stage is read by the second stage only
`timescale 1ns/1ns
`default_nettype none
module ssr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  // two stage capture into the local clock
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/ssr_mem.sv */
// Purpose: byte array behind the serial front end
// Assumes: one write per serial clock edge, read is combinational
// Notes: contents are undefined after power up
`timescale 1ns/1ns
`default_nettype none
module ssr_mem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);
  logic [DW-1:0] cells [0:(1<<AW)-1];

  // write port
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      cells[addr_in] <= wdata_in;
    end
  end

  // read port
  assign rdata_out = cells[addr_in];
endmodule
`default_nettype wire

/* File: verilog/ssr_slave.sv */
// Purpose: serial slave front end of an 8k by 8 byte memory
// Assumes: sck_in is the link clock and idles while not selected
// Notes: link logic runs on sck_in, status ports run on clk_in
`timescale 1ns/1ns
`default_nettype none
module ssr_slave #(
  parameter int MODE_POS = ssr_pkg::MODE_LSB,
  parameter ssr_pkg::ssr_mode_t MODE_WORD_CODE = ssr_pkg::MODE_WORD,
  parameter ssr_pkg::ssr_mode_t MODE_PAGE_CODE = ssr_pkg::MODE_PAGE,
  parameter ssr_pkg::ssr_mode_t MODE_BURST_CODE = ssr_pkg::MODE_BURST,
  parameter logic [ssr_pkg::DATA_W-1:0] STATUS_INIT = ssr_pkg::STATUS_RESET
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic hold_n_in,
  output var logic so_out,
  output var logic so_oe_n_out,
  output var ssr_pkg::ssr_mode_t mode_out,
  output var logic selected_out,
  output var logic paused_out,
  output var logic byte_written_out
);
  import ssr_pkg::*;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_READ,
    ST_WRITE,
    ST_SREAD,
    ST_SWRITE,
    ST_IGNORE
  } ssr_state_t;

  // transfer state, discarded whenever select is high
  typedef struct packed {
    ssr_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] shreg;
    logic [WADDR_W-1:0] addr;
    logic is_read;
  } ssr_eng_t;

  // state that outlives a transfer
  typedef struct packed {
    logic [DATA_W-1:0] status;
    logic wr_tog;
  } ssr_cfg_t;

  // falling edge output stage
  typedef struct packed {
    logic so;
    logic oe_n;
  } ssr_out_t;

  // system clock side
  typedef struct packed {
    ssr_mode_t mode;
    logic selected;
    logic paused;
    logic tog_prev;
    logic wr_pulse;
  } ssr_sys_t;

  localparam ssr_eng_t ENG_IDLE = '{state: ST_OPCODE, cnt: '0, shreg: '0, addr: '0,
                                    is_read: 1'b0};
  localparam ssr_out_t OUT_IDLE = '{so: 1'b0, oe_n: 1'b1};
  localparam int SYNC_W = MODE_W + 3;

  // mode field of a status byte
  function automatic ssr_mode_t mode_of(input logic [DATA_W-1:0] status);
    mode_of = status[MODE_POS +: MODE_W];
  endfunction

  // pointer step for page and burst modes
  function automatic logic [WADDR_W-1:0] step_ptr(input logic [WADDR_W-1:0] ptr,
                                                 input ssr_mode_t mode);
    logic [PAGE_W-1:0] low;
    low = ptr[PAGE_W-1:0] + 5'h01;
    if (mode == MODE_BURST_CODE) begin
      step_ptr = ptr + 13'h0001;
    end else begin
      step_ptr = {ptr[WADDR_W-1:PAGE_W], low};
    end
  endfunction

  // word mode moves one byte per access
  function automatic logic one_byte(input logic [DATA_W-1:0] status);
    one_byte = (mode_of(status) == MODE_WORD_CODE);
  endfunction

  ssr_eng_t eng;
  ssr_eng_t next_eng;
  ssr_cfg_t cfg;
  ssr_cfg_t next_cfg;
  ssr_out_t outq;
  ssr_out_t next_out;
  ssr_sys_t sys;
  ssr_sys_t next_sys;
  logic rst_sync;
  logic so_off;
  logic mem_we;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] rx_byte;
  logic [ADDR_W-1:0] rx_word;
  logic [DATA_W-1:0] tx_byte;
  logic [SYNC_W-1:0] sync_d;
  logic [SYNC_W-1:0] sync_q;
  logic sel_raw;
  logic pause_raw;
  logic sel_s;
  logic pause_s;
  logic tog_s;
  ssr_mode_t mode_s;

  // reset release into the system clock
  ssr_sync #(
    .WIDTH(1)
  ) u_rst_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in(1'b1),
    .q_out(rst_sync)
  );

  // byte array, addressed by the transfer pointer
  ssr_mem #(
    .AW(WADDR_W),
    .DW(DATA_W)
  ) u_mem (
    .clk_in(sck_in),
    .we_in(mem_we),
    .addr_in(eng.addr),
    .wdata_in(rx_byte),
    .rdata_out(mem_rdata)
  );

  // rising edge sequencer
  always_comb begin
    next_eng = eng;
    next_cfg = cfg;
    mem_we = 1'b0;
    rx_byte = {eng.shreg[DATA_W-2:0], si_in};
    rx_word = {eng.shreg[ADDR_W-2:0], si_in};
    if (hold_n_in) begin
      next_eng.shreg = rx_word;
      next_eng.cnt = eng.cnt + 4'h1;
      case (eng.state)
        // opcode phase
        ST_OPCODE: begin
          if (eng.cnt == OPC_LAST) begin
            next_eng.cnt = '0;
            case (rx_byte)
              OPC_READ: begin
                next_eng.state = ST_ADDR;
                next_eng.is_read = 1'b1;
              end
              OPC_WRITE: begin
                next_eng.state = ST_ADDR;
                next_eng.is_read = 1'b0;
              end
              OPC_SREAD: next_eng.state = ST_SREAD;
              OPC_SWRITE: next_eng.state = ST_SWRITE;
              default: next_eng.state = ST_IGNORE;
            endcase
          end
        end
        // address phase
        ST_ADDR: begin
          if (eng.cnt == ADDR_LAST) begin
            next_eng.cnt = '0;
            next_eng.addr = rx_word[WADDR_W-1:0];
            next_eng.state = eng.is_read ? ST_READ : ST_WRITE;
          end
        end
        // array data out
        ST_READ: begin
          if (eng.cnt == BYTE_LAST) begin
            next_eng.cnt = '0;
            next_eng.addr = step_ptr(eng.addr, mode_of(cfg.status));
            if (one_byte(cfg.status)) begin
              next_eng.state = ST_IGNORE;
            end
          end
        end
        // array data in
        ST_WRITE: begin
          if (eng.cnt == BYTE_LAST) begin
            // only a whole byte reaches the array
            mem_we = 1'b1;
            next_cfg.wr_tog = ~cfg.wr_tog;
            next_eng.cnt = '0;
            next_eng.addr = step_ptr(eng.addr, mode_of(cfg.status));
            if (one_byte(cfg.status)) begin
              next_eng.state = ST_IGNORE;
            end
          end
        end
        // status byte out, repeated
        ST_SREAD: begin
          if (eng.cnt == BYTE_LAST) begin
            next_eng.cnt = '0;
          end
        end
        // status byte in
        ST_SWRITE: begin
          if (eng.cnt == BYTE_LAST) begin
            next_cfg.status = rx_byte;
            next_eng.state = ST_IGNORE;
          end
        end
        // rest of frame ignored
        ST_IGNORE: next_eng.cnt = '0;
        default: next_eng.state = ST_IGNORE;
      endcase
    end
  end

  // transfer state cleared while deselected
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      eng <= ENG_IDLE;
    end else begin
      eng <= next_eng;
    end
  end

  // status register survives deselect
  always_ff @(posedge sck_in or negedge rst_sync) begin
    if (!rst_sync) begin
      cfg <= '{status: STATUS_INIT, wr_tog: 1'b0};
    end else begin
      cfg <= next_cfg;
    end
  end

  // falling edge output data and enable
  always_comb begin
    tx_byte = (eng.state == ST_SREAD) ? cfg.status : mem_rdata;
    next_out.so = tx_byte[~eng.cnt[2:0]];
    next_out.oe_n = !((eng.state == ST_READ) || (eng.state == ST_SREAD));
    if (!hold_n_in) begin
      next_out.oe_n = 1'b1;
    end
  end

  // float at once when deselected or paused with the clock low
  assign so_off = cs_n_in | (~hold_n_in & ~sck_in);

  // output register on the falling edge
  always_ff @(negedge sck_in or posedge so_off) begin
    if (so_off) begin
      outq <= OUT_IDLE;
    end else begin
      outq <= next_out;
    end
  end

  // pins straight from the falling edge flops
  assign so_out = outq.so;
  assign so_oe_n_out = outq.oe_n;

  // active high copies, so a synchroniser in reset reads as idle
  assign sel_raw = ~cs_n_in;
  assign pause_raw = ~hold_n_in;

  // link levels into the system clock
  assign sync_d = {sel_raw, pause_raw, cfg.wr_tog, mode_of(cfg.status)};

  ssr_sync #(
    .WIDTH(SYNC_W)
  ) u_link_sync (
    .clk_in(clk_in),
    .resetn_in(rst_sync),
    .d_in(sync_d),
    .q_out(sync_q)
  );

  assign sel_s = sync_q[SYNC_W-1];
  assign pause_s = sync_q[SYNC_W-2];
  assign tog_s = sync_q[SYNC_W-3];
  assign mode_s = sync_q[MODE_W-1:0];

  // status view; mode taken only while deselected, when it is stable
  always_comb begin
    next_sys = sys;
    next_sys.selected = sel_s;
    next_sys.paused = sel_s & pause_s;
    next_sys.tog_prev = tog_s;
    next_sys.wr_pulse = tog_s ^ sys.tog_prev;
    if (!sel_s) begin
      next_sys.mode = mode_s;
    end
  end

  // system clock register
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      sys <= '{mode: mode_of(STATUS_INIT), selected: 1'b0, paused: 1'b0,
               tog_prev: 1'b0, wr_pulse: 1'b0};
    end else begin
      sys <= next_sys;
    end
  end

  // status ports straight from registers
  assign mode_out = sys.mode;
  assign selected_out = sys.selected;
  assign paused_out = sys.paused;
  assign byte_written_out = sys.wr_pulse;
endmodule
`default_nettype wire

/* File: sim/ssr_host.sv */
// Purpose: spi host model for the serial memory slave
// Assumes: 64 ns link clock that idles low
// Notes: si moves when it carries nothing
`timescale 1ns/1ns
`default_nettype none
module ssr_host (
  input wire logic so_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  output logic hold_n_out
);
  logic [7:0] rx;
  // idle bus after power up
  initial begin
    sck_out = 1'h0;
    si_out = 1'h0;
    hold_n_out = 1'h1;
    // rising select once all processes run, so the slave clears its frame
    #1 cs_n_out = 1'h1;
  end
  // select, held low for the frame
  task sel;
    #7 cs_n_out = 1'h0;
    #32;
  endtask
  // shift n bits msb first, sample so before the rise
  task tx(input logic [7:0] b, input int n = 8);
    for (int i = 7; i > 7 - n; i--) begin
      si_out = b[i];
      #32 rx = {rx[6:0], so_in};
      sck_out = 1'h1;
      #32 sck_out = 1'h0;
    end
  endtask
  // end of frame
  task desel;
    cs_n_out = 1'h1;
    si_out = ~si_out;
    #40;
  endtask
  // pause with clock and si still moving
  task pause;
    hold_n_out = 1'h0;
    repeat (3) begin
      si_out = ~si_out;
      #32 sck_out = 1'h1;
      #32 sck_out = 1'h0;
    end
    hold_n_out = 1'h1;
  endtask
endmodule
`default_nettype wire

/* File: sim/ssr_slave_sva.sv */
// Purpose: port checks of the serial memory slave
// Assumes: status ports lag the link by about 3 clk cycles
// Notes: all checks sampled on clk_in
`timescale 1ns/1ns
`default_nettype none
module ssr_slave_sva (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic hold_n_in,
  input wire logic so_out,
  input wire logic so_oe_n_out,
  input wire ssr_pkg::ssr_mode_t mode_out,
  input wire logic selected_out,
  input wire logic paused_out,
  input wire logic byte_written_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // select level held long enough to pass the sync
  sequence s_on;
    !cs_n_in [*5];
  endsequence
  sequence s_off;
    cs_n_in [*5];
  endsequence
  // output and status relations
  property p_float; cs_n_in && $past(cs_n_in) |-> so_oe_n_out; endproperty
  a_float: assert property (p_float) else $error("so driven deselected");
  property p_hold_z; !hold_n_in && !sck_in && $past(!hold_n_in) |-> so_oe_n_out; endproperty
  a_hold_z: assert property (p_hold_z) else $error("so driven paused");
  property p_sck_hi; sck_in && $past(sck_in) && !cs_n_in |-> $stable(so_out); endproperty
  a_sck_hi: assert property (p_sck_hi) else $error("so moved, sck high");
  property p_sel; s_on |-> selected_out; endproperty
  a_sel: assert property (p_sel) else $error("selected low");
  property p_desel; s_off |-> !selected_out; endproperty
  a_desel: assert property (p_desel) else $error("selected high");
  property p_pause; (!cs_n_in && !hold_n_in) [*5] |-> paused_out; endproperty
  a_pause: assert property (p_pause) else $error("paused low");
  property p_run; hold_n_in [*5] |-> !paused_out; endproperty
  a_run: assert property (p_run) else $error("paused high");
  property p_mode; s_on |-> $stable(mode_out); endproperty
  a_mode: assert property (p_mode) else $error("mode moved");
  property p_commit; byte_written_out |-> selected_out ##1 !byte_written_out; endproperty
  a_commit: assert property (p_commit) else $error("bad commit pulse");
endmodule
bind ssr_slave ssr_slave_sva u_sva (.clk_in(clk_in), .resetn_in(resetn_in),
  .sck_in(sck_in), .cs_n_in(cs_n_in), .hold_n_in(hold_n_in), .so_out(so_out),
  .so_oe_n_out(so_oe_n_out), .mode_out(mode_out), .selected_out(selected_out),
  .paused_out(paused_out), .byte_written_out(byte_written_out));
`default_nettype wire

/* File: sim/ssr_slave_bench.sv */
// Purpose: self-checking bench of the serial memory slave
// Assumes: host model drives the link, byte map models the array
// Notes: about 28 us of traffic
`timescale 1ns/1ns
`default_nettype none
module ssr_slave_bench;
  import ssr_pkg::*;
  logic clk_in;
  logic resetn_in;
  wire logic sck, cs_n, si, hold_n;
  logic so, oe_n, sel, pau, bw;
  ssr_mode_t mode;
  ssr_mode_t m;
  int fail_count;
  int comparisons;
  int wr_exp;
  int wr_seen;
  int pause_seen;
  logic so_line;
  logic [7:0] mem [int];
  logic [31:0] seed = 32'h0000793B;
  logic [12:0] p;
  ssr_host h (.so_in(so_line), .sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n));
  ssr_slave dut (.clk_in(clk_in), .resetn_in(resetn_in), .sck_in(sck), .cs_n_in(cs_n),
    .si_in(si), .hold_n_in(hold_n), .so_out(so), .so_oe_n_out(oe_n), .mode_out(mode),
    .selected_out(sel), .paused_out(pau), .byte_written_out(bw));
  // a floated output shows the inverse of its last bit to the host
  assign so_line = oe_n ? ~so : so;
  // count commit pulses and paused cycles away from the launching edge
  always @(negedge clk_in) begin
    if (bw) wr_seen++;
    if (pau) pause_seen++;
  end
  // xorshift source
  function automatic logic [7:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // model pointer step per mode
  function automatic logic [12:0] nxt(input logic [12:0] a);
    if (m == MODE_PAGE) return {a[12:5], a[4:0] + 5'h01};
    return a + 13'h0001;
  endfunction
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // opcode then address, optional pause inside it
  task op(input logic [7:0] c, input logic [15:0] a, input bit hp = 0);
    h.sel;
    h.tx(c);
    h.tx(a[15:8]);
    if (hp) h.pause;
    h.tx(a[7:0]);
    chk("selected", 8'h01, 8'(sel));
    p = a[12:0];
  endtask
  task wr(input logic [15:0] a, input int n);
    logic [7:0] d;
    op(OPC_WRITE, a);
    repeat (n) begin
      d = rnd();
      h.tx(d);
      mem[p] = d;
      p = nxt(p);
    end
    wr_exp += n;
    h.desel;
  endtask
  task rd(input logic [15:0] a, input int n, input bit hp = 0);
    op(OPC_READ, a, hp);
    repeat (n) begin
      h.tx(rnd());
      chk("rd", mem[p], h.rx);
      p = nxt(p);
    end
    if (m == MODE_WORD) begin
      #4;
      chk("word", 8'h01, 8'(oe_n));
    end
    h.desel;
  endtask
  // status write, read back, mode port
  task setm(input ssr_mode_t v);
    m = v;
    h.sel;
    h.tx(OPC_SWRITE);
    h.tx({v, 6'h02});
    h.desel;
    h.sel;
    h.tx(OPC_SREAD);
    h.tx(rnd());
    chk("status", {v, 6'h02}, h.rx);
    h.desel;
    chk("mode", 8'(v), 8'(mode));
  endtask
  task stop_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'h0;
    forever #2 clk_in = ~clk_in;
  end
  // watchdog
  initial begin
    #100000;
    fail_count++;
    stop_test;
  end
  // main sequence
  initial begin
    resetn_in = 1'h0;
    fail_count = 0;
    comparisons = 0;
    wr_exp = 0;
    wr_seen = 0;
    pause_seen = 0;
    m = MODE_WORD;
    repeat (12) @(negedge clk_in);
    resetn_in = 1'h1;
    repeat (4) @(negedge clk_in);
    chk("idle", 8'h01, 8'(oe_n));
    setm(MODE_BURST);
    wr(16'hFFFF, 2);
    rd(16'h1FFF, 2);
    setm(MODE_PAGE);
    wr(16'h203F, 3);
    rd(16'h003F, 3);
    op(OPC_WRITE, 16'h0020);
    h.tx(~mem[32], 4);
    h.desel;
    rd(16'h0020, 1);
    rd(16'h0021, 1, 1);
    setm(MODE_WORD);
    rd(16'h0020, 1);
    h.sel;
    h.tx(8'hFF);
    h.tx(rnd());
    chk("unknown", 8'h01, 8'(oe_n));
    h.desel;
    chk("deselected", 8'h00, 8'(sel));
    chk("writes", 8'(wr_exp), 8'(wr_seen));
    chk("paused", 8'h01, 8'(pause_seen > 40 && pause_seen < 56));
    stop_test;
  end
endmodule
`default_nettype wire
